// file: core/bsp_pkg.sv
// Purpose: shared constants and carriers for the bridge short protection
// Assumes: 125 MHz clock, three half bridges
// Notes: level codes reach the analog comparators with high-side clamped to 2 and low-side code 0 replaced by the strap level
package bsp_pkg;

  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned NUM_PHASES = 3;

  // ----------------------------------------------------------------
  // timing figures in ns and derived cycle counts
  // ----------------------------------------------------------------
  localparam int unsigned FILT0_NS = 100;
  localparam int unsigned FILT1_NS = 1000;
  localparam int unsigned FILT2_NS = 2000;
  localparam int unsigned FILT3_NS = 3000;
  localparam int unsigned BLANK_NORM_NS = 750;
  localparam int unsigned BLANK_HIGH_NS = 1500;
  // least times round up to whole cycles
  localparam logic [9:0] FILT0_CYC =
    10'((FILT0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [9:0] FILT1_CYC =
    10'((FILT1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [9:0] FILT2_CYC =
    10'((FILT2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [9:0] FILT3_CYC =
    10'((FILT3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [9:0] BLANK_NORM_CYC =
    10'((BLANK_NORM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [9:0] BLANK_HIGH_CYC =
    10'((BLANK_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // reset values and code limits
  // ----------------------------------------------------------------
  localparam logic [3:0] LS_LEVEL_OTP_LO = 4'h6;
  localparam logic [3:0] LS_LEVEL_OTP_HI = 4'hc;
  localparam logic [3:0] HS_LEVEL_MIN = 4'h2;
  localparam logic [1:0] FILTER_RESET = 2'h1;
  localparam logic [1:0] RETRY_RESET = 2'h3;
  localparam logic [9:0] CNT_ZERO = 10'h000;
  localparam logic [9:0] CNT_ONE = 10'h001;
  localparam logic [1:0] RETRY_ONE = 2'h1;

  // configuration carried as one group of control bits
  typedef struct packed {
    logic [3:0] lowside_overcurrent_level;
    logic [3:0] highside_short_level;
    logic [1:0] filter_sel;
    logic [1:0] retry_limit;
    logic delay_high;
    logic lowside_detect_off;
    logic highside_detect_off;
    logic all_bridge_off;
    logic short_direct;
  } bsp_cfg_t;

  // per-phase fault flags
  typedef struct packed {
    logic [NUM_PHASES-1:0] gnd;
    logic [NUM_PHASES-1:0] supply;
  } bsp_flags_t;

endpackage

// file: core/bsp_protect.sv
// Purpose: short and overcurrent protection for three half bridges
// Assumes: comparator inputs synchronous to clk_in, fixed 125 MHz clock
// Notes: one retry is one blank-qualify-trip cycle of the faulted phase
//
// Notes on behaviour
// - watch high-side and low-side transistor drop on each bridge
// - low-side level is 4 bits, 15 least sensitive, default 6 or 12
// - high-side level runs from 2, most sensitive, to 15
// - filter select 0..3 gives 100ns, 1us default, 2us, 3us
// - retry up to programmed count 0..3, default 3, then latch off
// - blanking is 750ns when delay bit clear, 1500ns when set
// - low-side disable bit high turns off short-to-supply guard
// - high-side disable bit high turns off short-to-ground guard
// - all-bridge bit 0 stops one bridge, 1 (default) stops all
// - confirmed short sets its matching flag; the phase stops once retries are spent
// - after latch-off, disable then enable driver to restart
// - direct option passes every overcurrent pulse to fault pin
// - low-side path includes bottom shunt drop with transistor
`timescale 1ns/100ps

module bsp_protect (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic otp_level_high_in,
  input wire bsp_pkg::bsp_cfg_t cfg_in,
  input wire logic driver_enable_in,
  input wire logic [2:0] hs_drop_in,
  input wire logic [2:0] ls_drop_in,
  input wire logic [2:0] bridge_on_in,
  output logic [3:0] lowside_level_out,
  output logic [3:0] highside_level_out,
  output logic [2:0] bridge_enable_out,
  output bsp_pkg::bsp_flags_t flags_out,
  output logic fault_out
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] ls_reset_level;
    logic [2:0][9:0] blank_cnt;
    logic [2:0][9:0] hs_filt;
    logic [2:0][9:0] ls_filt;
    logic [2:0][1:0] retries;
    logic [2:0] off;
    logic latched;
    logic en_prev;
    bsp_pkg::bsp_flags_t flags;
    logic direct;
  } bsp_state_t;

  // reset image: strap default 6 until the strap is first sampled
  localparam bsp_state_t STATE_RESET = '{
    ls_reset_level: bsp_pkg::LS_LEVEL_OTP_LO,
    default: '0
  };

  bsp_state_t s_q;
  bsp_state_t s_d;
  logic [9:0] filt_len;
  logic [9:0] blank_len;
  logic [2:0] hs_hit;
  logic [2:0] ls_hit;
  logic [2:0] trip;
  logic restart;

  // filter and blank lengths from the configuration
  always_comb begin
    unique case (cfg_in.filter_sel)
      2'h0: filt_len = bsp_pkg::FILT0_CYC;
      2'h1: filt_len = bsp_pkg::FILT1_CYC;
      2'h2: filt_len = bsp_pkg::FILT2_CYC;
      2'h3: filt_len = bsp_pkg::FILT3_CYC;
    endcase
    blank_len = cfg_in.delay_high ? bsp_pkg::BLANK_HIGH_CYC
                                  : bsp_pkg::BLANK_NORM_CYC;
  end

  // level codes toward the comparators; high-side clamped to its floor
  always_comb begin
    lowside_level_out = s_q.ls_reset_level;
    if (cfg_in.lowside_overcurrent_level != 4'h0) begin
      lowside_level_out = cfg_in.lowside_overcurrent_level;
    end
    highside_level_out = cfg_in.highside_short_level;
    if (cfg_in.highside_short_level < bsp_pkg::HS_LEVEL_MIN) begin
      highside_level_out = bsp_pkg::HS_LEVEL_MIN;
    end
  end

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    hs_hit = '0;
    ls_hit = '0;
    trip = '0;
    s_d.en_prev = driver_enable_in;
    // strap followed only while the driver has been idle two cycles
    if (!s_q.en_prev && !driver_enable_in) begin
      s_d.ls_reset_level = otp_level_high_in ? bsp_pkg::LS_LEVEL_OTP_HI
                                             : bsp_pkg::LS_LEVEL_OTP_LO;
    end
    // a rising enable after a disable is the restart sequence
    restart = driver_enable_in && !s_q.en_prev;
    s_d.direct = 1'b0;
    for (int p = 0; p < bsp_pkg::NUM_PHASES; p++) begin
      // blanking restarts whenever the bridge switches or is off
      if (!bridge_on_in[p] || s_q.off[p]) begin
        s_d.blank_cnt[p] = blank_len;
      end else if (s_q.blank_cnt[p] != bsp_pkg::CNT_ZERO) begin
        s_d.blank_cnt[p] = s_q.blank_cnt[p] - bsp_pkg::CNT_ONE;
      end
      // spike filter: comparator must stay high for the filter length
      if (hs_drop_in[p] && !cfg_in.highside_detect_off &&
          s_q.blank_cnt[p] == bsp_pkg::CNT_ZERO) begin
        s_d.hs_filt[p] = s_q.hs_filt[p] + bsp_pkg::CNT_ONE;
      end else begin
        s_d.hs_filt[p] = bsp_pkg::CNT_ZERO;
      end
      // low-side comparator sees transistor plus bottom shunt drop
      if (ls_drop_in[p] && !cfg_in.lowside_detect_off &&
          s_q.blank_cnt[p] == bsp_pkg::CNT_ZERO) begin
        s_d.ls_filt[p] = s_q.ls_filt[p] + bsp_pkg::CNT_ONE;
      end else begin
        s_d.ls_filt[p] = bsp_pkg::CNT_ZERO;
      end
      hs_hit[p] = s_d.hs_filt[p] >= filt_len;
      ls_hit[p] = s_d.ls_filt[p] >= filt_len;
      trip[p] = hs_hit[p] || ls_hit[p];
      if (ls_drop_in[p] && !cfg_in.lowside_detect_off) begin
        s_d.direct = 1'b1;
      end
      if (trip[p]) begin
        // flags are only ever set here; nothing but reset clears them
        s_d.flags.gnd[p] = s_q.flags.gnd[p] | hs_hit[p];
        s_d.flags.supply[p] = s_q.flags.supply[p] | ls_hit[p];
        s_d.hs_filt[p] = bsp_pkg::CNT_ZERO;
        s_d.ls_filt[p] = bsp_pkg::CNT_ZERO;
        if (s_q.retries[p] >= cfg_in.retry_limit) begin
          s_d.latched = 1'b1;
          s_d.off[p] = 1'b1;
        end else begin
          s_d.retries[p] = s_q.retries[p] + bsp_pkg::RETRY_ONE;
          s_d.blank_cnt[p] = blank_len; // retry: re-blank and re-check
        end
      end
    end
    if (restart && !(|trip)) begin
      s_d.retries = '0;
      s_d.off = '0;
      s_d.latched = 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_q <= STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs: all-bridge mode stops every phase on any latched fault
  always_comb begin
    if (cfg_in.all_bridge_off && s_q.latched) begin
      bridge_enable_out = '0;
    end else begin
      bridge_enable_out = ~s_q.off & {3{driver_enable_in}};
    end
    flags_out = s_q.flags;
    fault_out = cfg_in.short_direct ? s_q.direct : s_q.latched;
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  property p_latch_stops;
    @(posedge clk_in) disable iff (!resetn_in)
    (s_q.latched && cfg_in.all_bridge_off) |-> bridge_enable_out == 3'h0;
  endproperty
  a_latch_stops: assert property (p_latch_stops)
    else $error("bridges on while latched in all mode");

  property p_flag_sticky;
    @(posedge clk_in) disable iff (!resetn_in)
    $rose(flags_out.gnd[0]) |=> flags_out.gnd[0] [*4];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("ground flag dropped");

  property p_hs_off;
    @(posedge clk_in) disable iff (!resetn_in)
    cfg_in.highside_detect_off |-> s_d.hs_filt == '0;
  endproperty
  a_hs_off: assert property (p_hs_off)
    else $error("high-side filter runs while disabled");

  property p_ls_off;
    @(posedge clk_in) disable iff (!resetn_in)
    cfg_in.lowside_detect_off |-> s_d.ls_filt == '0;
  endproperty
  a_ls_off: assert property (p_ls_off)
    else $error("low-side filter runs while disabled");

  property p_restart;
    @(posedge clk_in) disable iff (!resetn_in)
    (restart && !(|trip)) |=> !s_q.latched && s_q.retries == '0;
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart did not clear shutdown");

  property p_blank;
    @(posedge clk_in) disable iff (!resetn_in)
    (resetn_in && !bridge_on_in[0]) |=>
      s_q.blank_cnt[0] == $past(blank_len);
  endproperty
  a_blank: assert property (p_blank)
    else $error("blanking not reloaded");

  property p_hs_floor;
    @(posedge clk_in) disable iff (!resetn_in)
    highside_level_out >= bsp_pkg::HS_LEVEL_MIN;
  endproperty
  a_hs_floor: assert property (p_hs_floor)
    else $error("high-side level below floor");

  property p_latch_limit;
    @(posedge clk_in) disable iff (!resetn_in)
    (trip[2] && s_q.retries[2] < cfg_in.retry_limit) |=> !s_q.off[2];
  endproperty
  a_latch_limit: assert property (p_latch_limit)
    else $error("latched before retries spent");

  property p_direct;
    @(posedge clk_in) disable iff (!resetn_in)
    (cfg_in.short_direct && ls_drop_in[0] && !cfg_in.lowside_detect_off)
      |=> fault_out || !cfg_in.short_direct;
  endproperty
  a_direct: assert property (p_direct)
    else $error("direct pulse not passed to fault");

endmodule // bsp_protect

// file: test/bsp_bridge_model.sv
// Purpose: half bridge and comparator model for the protection block
// Assumes: shorts are commanded by the bench
// Notes: a bridge that is switched off shows no drop
`timescale 1ns/100ps

module bsp_bridge_model (
  input wire logic clk_in,
  input wire logic [2:0] enable_in,
  input wire logic [2:0] gnd_short_in,
  input wire logic [2:0] sup_short_in,
  output logic [2:0] on_out,
  output logic [2:0] hs_drop_out,
  output logic [2:0] ls_drop_out
);
  // one stage stands in for gate switching delay
  always_ff @(posedge clk_in) begin
    on_out <= enable_in;
    hs_drop_out <= gnd_short_in & enable_in;
    ls_drop_out <= sup_short_in & enable_in;
  end
endmodule // bsp_bridge_model

// file: test/tb_top.sv
// Purpose: self-checking bench for the short protection block
// Assumes: bridges follow their enables one cycle late
// Notes: trip times are checked inside small windows, not exactly
`timescale 1ns/100ps

module tb_top;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic otp_in = 1'b0;
  logic drv_en = 1'b0;
  logic [2:0] gnd_short = 3'h0;
  logic [2:0] sup_short = 3'h0;
  bsp_pkg::bsp_cfg_t cfg_in = '0;
  bsp_pkg::bsp_cfg_t c;
  bsp_pkg::bsp_cfg_t base;
  logic [2:0] on_w, hs_w, ls_w, en_w;
  logic [3:0] ls_lvl, hs_lvl;
  bsp_pkg::bsp_flags_t flags;
  logic fault, hit;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int nf, no, e;
  int b = int'(bsp_pkg::BLANK_NORM_CYC);
  int filt[4] = '{int'(bsp_pkg::FILT0_CYC), int'(bsp_pkg::FILT1_CYC),
                  int'(bsp_pkg::FILT2_CYC), int'(bsp_pkg::FILT3_CYC)};

  bsp_protect u_dut (.clk_in(clk_in), .resetn_in(resetn_in),
    .otp_level_high_in(otp_in), .cfg_in(cfg_in),
    .driver_enable_in(drv_en), .hs_drop_in(hs_w), .ls_drop_in(ls_w),
    .bridge_on_in(on_w), .lowside_level_out(ls_lvl),
    .highside_level_out(hs_lvl), .bridge_enable_out(en_w),
    .flags_out(flags), .fault_out(fault));
  bsp_bridge_model u_bridge (.clk_in(clk_in), .enable_in(en_w),
    .gnd_short_in(gnd_short), .sup_short_in(sup_short), .on_out(on_w),
    .hs_drop_out(hs_w), .ls_drop_out(ls_w));

  // clock and hang guard, ceiling well above the twelve trips
  always #4 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      close_out();
    end
  end

  // ------------------------------------------------------------
  // tasks: every driver starts on an edge and ends settled
  // ------------------------------------------------------------
  task automatic chk_val(input string what, input logic [5:0] exp,
                         input logic [5:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic chk_win(input string what, input int lo, input int hi,
                         input int n);
    checks_done++;
    if (n < lo || n > hi) begin
      errors++;
      $display("wrong value %s exp %0d..%0d got %0d", what, lo, hi, n);
    end
  endtask
  task automatic do_reset();
    @(posedge clk_in);
    resetn_in <= 1'b0;
    drv_en <= 1'b0;
    gnd_short <= 3'h0;
    sup_short <= 3'h0;
    repeat (8) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
  endtask
  // shorts are present before enable, so timing starts at enable
  task automatic trip(input bsp_pkg::bsp_cfg_t t, input logic [2:0] g,
                      input logic [2:0] s);
    do_reset();
    @(posedge clk_in);
    cfg_in <= t;
    gnd_short <= g;
    sup_short <= s;
    @(posedge clk_in);
    drv_en <= 1'b1;
    nf = -1;
    no = -1;
    for (int n = 1; n <= 600; n++) begin
      @(posedge clk_in);
      #1;
      if (nf < 0 && flags !== 6'h00) nf = n;
      if (no < 0 && en_w !== 3'h7) no = n;
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    do_reset();
    chk_val("ls default", 6'h06, {2'h0, ls_lvl});
    chk_val("hs clamp", 6'h02, {2'h0, hs_lvl});
    @(posedge clk_in);
    otp_in <= 1'b1;
    base = '0;
    base.lowside_overcurrent_level = 4'hf;
    base.highside_short_level = 4'hf;
    base.delay_high = 1'b0;
    c = base;
    c.highside_short_level = 4'h1;
    cfg_in <= c;
    repeat (4) @(posedge clk_in);
    #1;
    chk_val("ls cfg", 6'h0f, {2'h0, ls_lvl});
    chk_val("hs low", 6'h02, {2'h0, hs_lvl});
    c.lowside_overcurrent_level = 4'h0;
    @(posedge clk_in);
    cfg_in <= c;
    @(posedge clk_in);
    #1;
    chk_val("ls strap", 6'h0c, {2'h0, ls_lvl});
    $display("level test done");
    for (int k = 0; k < 4; k++) begin
      c = base;
      c.filter_sel = 2'(k);
      trip(c, 3'h1, 3'h0);
      e = b + filt[k];
      chk_win("trip time", e - 2, e + 6, nf);
      chk_val("gnd flag", 6'h08, flags);
      chk_val("one off", 6'h06, {3'h0, en_w});
      chk_val("latch fault", 6'h01, {5'h00, fault});
    end
    c = base;
    c.delay_high = 1'b1;
    c.filter_sel = 2'h0;
    trip(c, 3'h1, 3'h0);
    e = int'(bsp_pkg::BLANK_HIGH_CYC) + filt[0];
    chk_win("long blank", e - 2, e + 6, nf);
    $display("timing test done");
    c = base;
    c.all_bridge_off = 1'b1;
    trip(c, 3'h0, 3'h2);
    chk_val("sup flag", 6'h02, flags);
    chk_val("all off", 6'h00, {3'h0, en_w});
    @(posedge clk_in);
    drv_en <= 1'b0;
    sup_short <= 3'h0;
    repeat (3) @(posedge clk_in);
    drv_en <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    chk_val("restart", 6'h07, {3'h0, en_w});
    chk_val("sticky", 6'h02, flags);
    chk_val("fault clear", 6'h00, {5'h00, fault});
    $display("shutdown test done");
    for (int r = 0; r < 4; r++) begin
      c = base;
      c.filter_sel = 2'h0;
      c.retry_limit = 2'(r);
      trip(c, 3'h4, 3'h0);
      e = (r + 1) * (b + filt[0]);
      chk_win("first flag", b + filt[0] - 2, b + filt[0] + 6, nf);
      chk_win("latch off", e - 2, e + 4 * r + 6, no);
    end
    $display("retry test done");
    for (int i = 0; i < 2; i++) begin
      c = base;
      c.highside_detect_off = (i == 0);
      c.lowside_detect_off = (i == 1);
      trip(c, (i == 0) ? 3'h7 : 3'h0, (i == 1) ? 3'h7 : 3'h0);
      chk_val("off flags", 6'h00, flags);
      chk_val("off bridges", 6'h07, {3'h0, en_w});
    end
    $display("disable test done");
    do_reset();
    c = base;
    c.short_direct = 1'b1;
    @(posedge clk_in);
    cfg_in <= c;
    drv_en <= 1'b1;
    repeat (4) @(posedge clk_in);
    sup_short <= 3'h1;
    @(posedge clk_in);
    sup_short <= 3'h0;
    hit = 1'b0;
    repeat (4) begin
      @(posedge clk_in);
      #1;
      hit = hit | fault;
    end
    chk_val("direct pulse", 6'h01, {5'h00, hit});
    repeat (4) @(posedge clk_in);
    #1;
    chk_val("direct clear", 6'h00, {5'h00, fault});
    $display("direct test done");
    close_out();
  end
endmodule // tb_top
